// ---- sar_pkg.sv ----
// shared constants for the sar converter serial readout link
`default_nettype none

package sar_pkg;

   // **********************************************************
   // clocks
   // **********************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCLK_MIN_KHZ = 500;
   localparam int SCLK_MAX_MHZ_FAST = 48;
   localparam int SCLK_MAX_MHZ_SLOW = 16;
   // half period of the serial clock in system clock cycles
   localparam int SCLK_HALF_CYC = 5;
   localparam int SCLK_PERIOD_NS = 2 * SCLK_HALF_CYC * CLK_PERIOD_NS;

   // **********************************************************
   // converter variants and framing
   // **********************************************************
   localparam int RES_BITS_12 = 12;
   localparam int RES_BITS_10 = 10;
   localparam int RES_BITS_8 = 8;
   localparam int CONV_PERIODS_12 = 14;
   localparam int CONV_PERIODS_10 = 12;
   localparam int CONV_PERIODS_8 = 10;
   localparam int LEAD_ZEROS = 2;
   localparam int FRAME_SHORT = 14;
   localparam int FRAME_LONG = 16;
   localparam int FIFO_DEPTH = 8;

   // **********************************************************
   // link timing
   // **********************************************************
   localparam int ACQUISITION_WINDOW_NS = 60;
   localparam int BUS_QUIET_GAP_NS = 4;
   localparam int WAKEUP_DELAY_NS = 1000;
   localparam int ACQ_CYC_RAW = (ACQUISITION_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACQ_CYC = (ACQ_CYC_RAW < 1) ? 1 : ACQ_CYC_RAW;
   localparam int QUIET_CYC_RAW = (BUS_QUIET_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QUIET_CYC = (QUIET_CYC_RAW < 1) ? 1 : QUIET_CYC_RAW;
   localparam int GAP_CYC = (ACQ_CYC > QUIET_CYC) ? ACQ_CYC : QUIET_CYC;
   localparam int WAKEUP_CYC_RAW = (WAKEUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKEUP_CYC = (WAKEUP_CYC_RAW < 1) ? 1 : WAKEUP_CYC_RAW;

   // **********************************************************
   // reset values
   // **********************************************************
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam logic [15:0] SHIFT_RESET = 16'h0000;

endpackage

`default_nettype wire

// ---- sar_link_if.sv ----
// serial link between the converter and its host controller
`timescale 1ns/1ns
`default_nettype none

interface sar_link_if;
   logic sclk;              // serial clock, made by the host
   logic cs_n;              // frame select, low during a frame
   logic serial_result_out; // data bit driven by the converter
   logic serial_result_oe;  // high while the converter drives data
   logic line_level;        // wire level, pulled low when released

   assign line_level = serial_result_oe & serial_result_out;

   modport dev (
      input sclk,
      input cs_n,
      output serial_result_out,
      output serial_result_oe
   );

   modport host (
      output sclk,
      output cs_n,
      input line_level
   );
endinterface

`default_nettype wire

// ---- sar_adc_dev.sv ----
// converter end: samples, converts and shifts the result out
`timescale 1ns/1ns
`default_nettype none

module sar_adc_dev #(
   parameter int RES_BITS = sar_pkg::RES_BITS_12
) (
   sar_link_if.dev lnk,               // serial link
   input wire logic RSTN,             // asynchronous reset, active low
   input wire logic [11:0] ANALOG_CODE, // input level as a code
   output logic CONV_BUSY,            // conversion in progress
   output logic [11:0] LAST_CODE,     // last sampled code
   output logic FRAME_ACTIVE          // frame selected
);

   // **********************************************************
   // variant constants
   // **********************************************************
   localparam int CONV_PER = (RES_BITS == sar_pkg::RES_BITS_12) ? sar_pkg::CONV_PERIODS_12 :
                             (RES_BITS == sar_pkg::RES_BITS_10) ? sar_pkg::CONV_PERIODS_10 :
                             sar_pkg::CONV_PERIODS_8;
   localparam logic [4:0] FRAME_END = 5'(sar_pkg::FRAME_LONG);
   localparam logic [4:0] LEAD = 5'(sar_pkg::LEAD_ZEROS);
   localparam logic [4:0] BITS_END = 5'(sar_pkg::LEAD_ZEROS + RES_BITS);
   localparam logic [4:0] TOP_IDX = 5'(sar_pkg::LEAD_ZEROS + RES_BITS - 1);
   localparam logic [4:0] CONV_END = 5'(CONV_PER);
   localparam logic [11:0] CODE_MASK = (12'h001 << RES_BITS) - 12'h001;

   // **********************************************************
   // frame state
   // **********************************************************
   logic frame_rst_n;
   logic [4:0] fall_cnt_reg;
   logic [4:0] fall_cnt_next;
   logic out_bit_reg;
   logic out_bit_next;
   logic released_reg;
   logic taken_reg;
   logic [11:0] code_reg;
   logic [4:0] bit_idx;
   logic in_window;

   // frame logic is held clear while the frame select is high
   assign frame_rst_n = RSTN & ~lnk.cs_n;
   assign fall_cnt_next = (fall_cnt_reg == FRAME_END) ? fall_cnt_reg : fall_cnt_reg + 5'h01;
   assign bit_idx = TOP_IDX - fall_cnt_next;
   assign in_window = (fall_cnt_next >= LEAD) && (fall_cnt_next < BITS_END);
   // msb first, straight binary, zeros before and after
   assign out_bit_next = in_window ? code_reg[bit_idx[3:0]] : 1'h0;

   // sample taken on the first rising edge of the frame
   always_ff @(posedge lnk.sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         taken_reg <= 1'h0;
      end else begin
         taken_reg <= 1'h1;
      end
   end

   always_ff @(posedge lnk.sclk or negedge RSTN) begin
      if (!RSTN) begin
         code_reg <= sar_pkg::CODE_RESET;
      end else if (!lnk.cs_n && !taken_reg) begin
         code_reg <= ANALOG_CODE & CODE_MASK;
      end
   end

   // each bit is presented after a falling edge
   always_ff @(negedge lnk.sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         fall_cnt_reg <= 5'h00;
         out_bit_reg <= 1'h0;
      end else begin
         fall_cnt_reg <= fall_cnt_next;
         out_bit_reg <= out_bit_next;
      end
   end

   // output released after the falling edge past the last bit
   always_ff @(negedge lnk.sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         released_reg <= 1'h0;
      end else if (fall_cnt_next == FRAME_END) begin
         released_reg <= 1'h1;
      end
   end

   // **********************************************************
   // outputs
   // **********************************************************
   assign lnk.serial_result_out = out_bit_reg;
   assign lnk.serial_result_oe = frame_rst_n & ~released_reg;
   assign CONV_BUSY = frame_rst_n & (fall_cnt_reg < CONV_END);
   assign LAST_CODE = code_reg;
   assign FRAME_ACTIVE = frame_rst_n;

endmodule // sar_adc_dev

`default_nettype wire

// ---- sar_host.sv ----
// host end: makes the serial clock, frames reads and buffers results
`timescale 1ns/1ns
`default_nettype none

// **********************************************************
// result buffer
// **********************************************************
module sar_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic clk,                // clock
   input wire logic rst_n,              // asynchronous reset, active low
   input wire logic in_valid,           // write request
   output logic in_ready,               // room for a word
   input wire logic [WIDTH-1:0] in_data, // word written
   output logic out_valid,              // word available
   input wire logic out_ready,          // word taken
   output logic [WIDTH-1:0] out_data    // oldest word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic do_wr;
   logic do_rd;
   logic full;
   logic empty;

   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && !empty;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign do_wr = in_valid && !full;
   assign do_rd = out_ready && !empty;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + (AW+1)'(do_wr);
         rd_ptr_reg <= rd_ptr_reg + (AW+1)'(do_rd);
      end
   end
endmodule // sar_fifo

// What the link does, at the host and converter ends
// - fourteen clock frame: two zeros, twelve bits
// - sixteen clock frame adds two trailing zeros
// - conversion lasts fourteen, twelve or ten periods
// - serial clock between 500 kHz and limit
// - keep acquisition window before next select
// - keep quiet gap after data release
// - wait wakeup delay before trusting conversions
// - data released on select rise or end
// - data driven after select fall, per falling edge
module sar_host (
   input wire logic CLK,                // system clock
   input wire logic RSTN,               // asynchronous reset, active low
   sar_link_if.host lnk,                // serial link
   input wire logic WAKE_REQ,           // restart the wakeup delay, taken only when idle
   output logic AWAKE,                  // wakeup delay has passed
   input wire logic REQ_VALID,          // request one conversion
   output logic REQ_READY,              // request accepted when high and WAKE_REQ is low
   input wire logic LONG_FRAME,         // sixteen clock frame when high
   output logic RES_VALID,              // result available
   input wire logic RES_READY,          // result taken
   output logic [11:0] RES_DATA,        // converted code
   output logic ZERO_FAULT              // last frame had a nonzero pad bit
);

   // **********************************************************
   // local constants
   // **********************************************************
   localparam logic [3:0] HALF_LAST = 4'(sar_pkg::SCLK_HALF_CYC - 1);
   localparam logic [3:0] GAP_LAST = 4'(sar_pkg::GAP_CYC - 1);
   localparam logic [3:0] WAKE_LAST = 4'(sar_pkg::WAKEUP_CYC - 1);
   localparam logic [4:0] LEN_SHORT = 5'(sar_pkg::FRAME_SHORT);
   localparam logic [4:0] LEN_LONG = 5'(sar_pkg::FRAME_LONG);

   typedef enum logic [2:0] {
      ST_WAKE,
      ST_IDLE,
      ST_LOW,
      ST_HIGH,
      ST_PUSH,
      ST_GAP
   } sar_host_state_t;

   // **********************************************************
   // data input synchroniser
   // **********************************************************
   logic sync1_reg;
   logic sync2_reg;
   logic sync3_reg;
   logic filt_reg;
   logic filt_next;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sync1_reg <= 1'h0;
         sync2_reg <= 1'h0;
         sync3_reg <= 1'h0;
         filt_reg <= 1'h0;
      end else begin
         sync1_reg <= lnk.line_level;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         filt_reg <= filt_next;
      end
   end

   assign filt_next = (sync2_reg == sync3_reg) ? sync3_reg : filt_reg;

   // **********************************************************
   // frame sequencer
   // **********************************************************
   sar_host_state_t state_reg;
   logic [3:0] cnt_reg;
   logic [4:0] bit_reg;
   logic [4:0] bit_next;
   logic [4:0] len_reg;
   logic [15:0] shift_reg;
   logic [15:0] shift_next;
   logic sclk_reg;
   logic cs_n_reg;
   logic long_reg;
   logic fault_reg;
   logic cnt_done;
   logic start;
   logic fifo_in_ready;
   logic push_valid;
   logic [11:0] push_data;
   logic pad_bad;

   assign cnt_done = (cnt_reg == HALF_LAST);
   assign start = REQ_VALID && REQ_READY;
   assign bit_next = bit_reg + 5'h01;
   assign shift_next = {shift_reg[14:0], filt_next};
   assign REQ_READY = (state_reg == ST_IDLE) && fifo_in_ready;
   assign push_valid = (state_reg == ST_PUSH);
   // result position depends on the frame length
   assign push_data = long_reg ? shift_reg[13:2] : shift_reg[11:0];
   assign pad_bad = long_reg ? ((shift_reg[15:14] != 2'h0) || (shift_reg[1:0] != 2'h0)) :
                               (shift_reg[13:12] != 2'h0);

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_reg <= ST_WAKE;
         cnt_reg <= 4'h0;
         bit_reg <= 5'h00;
         len_reg <= LEN_SHORT;
         shift_reg <= sar_pkg::SHIFT_RESET;
         sclk_reg <= 1'h0;
         cs_n_reg <= 1'h1;
         long_reg <= 1'h0;
         fault_reg <= 1'h0;
      end else begin
         case (state_reg)
            ST_WAKE: begin
               // conversions are not trusted until the delay ends
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_reg == WAKE_LAST) begin
                  cnt_reg <= 4'h0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (WAKE_REQ) begin
                  cnt_reg <= 4'h0;
                  state_reg <= ST_WAKE;
               end else if (start) begin
                  cs_n_reg <= 1'h0;
                  long_reg <= LONG_FRAME;
                  len_reg <= LONG_FRAME ? LEN_LONG : LEN_SHORT;
                  bit_reg <= 5'h00;
                  cnt_reg <= 4'h0;
                  state_reg <= ST_LOW;
               end
            end
            ST_LOW: begin
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_done) begin
                  // rising edge: sample the bit presented last fall
                  cnt_reg <= 4'h0;
                  sclk_reg <= 1'h1;
                  shift_reg <= shift_next;
                  bit_reg <= bit_next;
                  if (bit_next == len_reg) begin
                     cs_n_reg <= 1'h1;
                     state_reg <= ST_PUSH;
                  end else begin
                     state_reg <= ST_HIGH;
                  end
               end
            end
            ST_HIGH: begin
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_done) begin
                  cnt_reg <= 4'h0;
                  sclk_reg <= 1'h0;
                  state_reg <= ST_LOW;
               end
            end
            ST_PUSH: begin
               sclk_reg <= 1'h0;
               if (fifo_in_ready) begin
                  fault_reg <= pad_bad;
                  cnt_reg <= 4'h0;
                  state_reg <= ST_GAP;
               end
            end
            ST_GAP: begin
               // select stays high for acquisition and quiet time
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_reg == GAP_LAST) begin
                  cnt_reg <= 4'h0;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // **********************************************************
   // result buffer
   // **********************************************************
   sar_fifo #(
      .WIDTH(sar_pkg::RES_BITS_12),
      .DEPTH(sar_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK),
      .rst_n(RSTN),
      .in_valid(push_valid),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(RES_VALID),
      .out_ready(RES_READY),
      .out_data(RES_DATA)
   );

   // **********************************************************
   // outputs
   // **********************************************************
   assign lnk.sclk = sclk_reg;
   assign lnk.cs_n = cs_n_reg;
   assign AWAKE = (state_reg != ST_WAKE);
   assign ZERO_FAULT = fault_reg;

endmodule // sar_host

`default_nettype wire

// ---- sar_link_properties.sv ----
// concurrent checks on the serial link between converter and host
`timescale 1ns/1ns
`default_nettype none

module sar_link_properties (
   input wire logic CLK,               // system clock
   input wire logic RSTN,              // reset, active low
   input wire logic sclk,              // serial clock
   input wire logic cs_n,              // frame select
   input wire logic serial_result_out, // data bit
   input wire logic serial_result_oe,  // data enable
   input wire logic line_level         // wire level
);
   // **********************************************************
   // helper counters
   // **********************************************************
   logic sclk_q_reg;
   logic [7:0] cyc_reg;
   logic [4:0] rise_reg;
   logic sclk_rise;
   assign sclk_rise = sclk & ~sclk_q_reg;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_q_reg <= 1'b0;
         cyc_reg <= 8'h00;
         rise_reg <= 5'h00;
      end else begin
         sclk_q_reg <= sclk;
         cyc_reg <= cs_n ? 8'h00 : cyc_reg + 8'h01;
         rise_reg <= cs_n ? 5'h00 : rise_reg + {4'h0, sclk_rise};
      end
   end

   // **********************************************************
   // assertions
   // **********************************************************
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);
   sequence s_low_phase;
      !sclk [*5] ##1 sclk;
   endsequence
   sequence s_high_phase;
      sclk [*5] ##1 !sclk;
   endsequence
   a_idle_release: assert property (cs_n |-> !serial_result_oe)
      else $error("data driven while deselected");
   a_select_drive: assert property ($fell(cs_n) |-> serial_result_oe)
      else $error("data not driven after select");
   a_bit_hold: assert property (!cs_n && !$fell(cs_n) && !$fell(sclk)
      |-> $stable(serial_result_out))
      else $error("data changed without a falling edge");
   a_first_rise: assert property ($fell(cs_n) |-> s_low_phase)
      else $error("first serial clock rise misplaced");
   a_high_phase: assert property ($rose(sclk) && !cs_n |-> s_high_phase)
      else $error("serial clock high phase wrong");
   a_low_phase: assert property ($fell(sclk) && !cs_n |-> s_low_phase)
      else $error("serial clock low phase wrong");
   a_sclk_idle: assert property (cs_n && $past(cs_n) |-> !sclk)
      else $error("serial clock runs outside a frame");
   a_frame_count: assert property ($rose(cs_n)
      |-> (rise_reg == 5'h0D) || (rise_reg == 5'h0F))
      else $error("frame ended on a wrong edge count");
   a_lead_zeros: assert property (!cs_n && (cyc_reg < 8'h14) |-> !line_level)
      else $error("leading bit not zero");
   a_trail_zeros: assert property (!cs_n && (cyc_reg >= 8'h8C) |-> !line_level)
      else $error("trailing bit not zero");
   a_acq_gap: assert property ($rose(cs_n) |-> cs_n [*3])
      else $error("next frame started too soon");
endmodule // sar_link_properties

`default_nettype wire

// ---- sar_adc_serial_readout_tb.sv ----
// self-checking bench for host and converter ends of the link
`timescale 1ns/1ns
`default_nettype none

module sar_adc_serial_readout_tb;
   logic clk, rstn, wake_req, awake, req_valid, req_ready, long_frame;
   logic res_valid, res_ready, zero_fault, conv_busy, frame_active, busy2, active2;
   logic [11:0] analog_code, res_data, last_code, code2, last2;
   logic busy3, active3, line_q;
   logic [11:0] last3;
   int fail_count, comparisons;
   int cycles = 0;

   // **********************************************************
   // design and checker
   // **********************************************************
   sar_link_if i_sar_link_if ();
   sar_link_if i_sar_link_if_b ();
   sar_link_if i_sar_link_if_c ();
   sar_host i_sar_host (.CLK(clk), .RSTN(rstn), .lnk(i_sar_link_if.host), .WAKE_REQ(wake_req),
      .AWAKE(awake), .REQ_VALID(req_valid), .REQ_READY(req_ready), .LONG_FRAME(long_frame),
      .RES_VALID(res_valid), .RES_READY(res_ready), .RES_DATA(res_data), .ZERO_FAULT(zero_fault));
   sar_adc_dev i_sar_adc_dev (.lnk(i_sar_link_if.dev), .RSTN(rstn), .ANALOG_CODE(analog_code),
      .CONV_BUSY(conv_busy), .LAST_CODE(last_code), .FRAME_ACTIVE(frame_active));
   sar_adc_dev #(.RES_BITS(sar_pkg::RES_BITS_8)) i_sar_adc_dev_b (.lnk(i_sar_link_if_b.dev),
      .RSTN(rstn), .ANALOG_CODE(code2), .CONV_BUSY(busy2), .LAST_CODE(last2),
      .FRAME_ACTIVE(active2));
   sar_adc_dev #(.RES_BITS(sar_pkg::RES_BITS_10)) i_sar_adc_dev_c (.lnk(i_sar_link_if_c.dev),
      .RSTN(rstn), .ANALOG_CODE(code2), .CONV_BUSY(busy3), .LAST_CODE(last3),
      .FRAME_ACTIVE(active3));
   sar_link_properties i_sar_link_properties (.CLK(clk), .RSTN(rstn),
      .sclk(i_sar_link_if.sclk), .cs_n(i_sar_link_if.cs_n),
      .serial_result_out(i_sar_link_if.serial_result_out),
      .serial_result_oe(i_sar_link_if.serial_result_oe), .line_level(i_sar_link_if.line_level));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // wire level half a cycle before each edge, clear of the select race
   always @(negedge clk) begin
      line_q = i_sar_link_if.line_level;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         summarize();
      end
   end

   // **********************************************************
   // shared tasks
   // **********************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic wake_wait();
      int n;
      n = 0;
      while (awake !== 1'b1 && n < 100) begin
         tick();
         n++;
      end
      check(16'(n), 16'(sar_pkg::WAKEUP_CYC));
   endtask

   task automatic start_req(input logic lf, input logic [11:0] code);
      int n;
      analog_code = code;
      long_frame = lf;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 400) begin
         tick();
         n++;
      end
      tick();
      req_valid = 1'b0;
   endtask

   task automatic run_frame(input logic lf, input logic [11:0] code);
      logic [15:0] bits;
      bits = 16'h0000;
      start_req(lf, code);
      for (int i = 0; i < (lf ? 16 : 14); i++) begin
         @(posedge i_sar_link_if.sclk);
         bits = {bits[14:0], line_q};
         if (i == 12) check({14'h0000, conv_busy, frame_active}, 16'h0003);
      end
      check(bits, lf ? {2'b00, code, 2'b00} : {4'h0, code});
      tick();
      check({14'h0000, i_sar_link_if.cs_n, i_sar_link_if.serial_result_oe}, 16'h0002);
      check({15'h0000, frame_active}, 16'h0000);
      check({4'h0, last_code}, {4'h0, code});
   endtask

   task automatic pop_check(input logic [11:0] code);
      int n;
      tick();
      n = 0;
      while (res_valid !== 1'b1 && n < 20) begin
         tick();
         n++;
      end
      check({4'h0, res_data}, {4'h0, code});
      check({14'h0000, zero_fault, conv_busy}, 16'h0000);
      res_ready = 1'b1;
      tick();
      res_ready = 1'b0;
   endtask

   // **********************************************************
   // scenarios
   // **********************************************************
   task automatic t_wake();
      check({15'h0000, req_ready}, 16'h0000);
      wake_wait();
      wake_req = 1'b1;
      tick();
      wake_req = 1'b0;
      req_valid = 1'b1;
      check({14'h0000, awake, req_ready}, 16'h0000);
      wake_wait();
      req_valid = 1'b0;
      check({15'h0000, i_sar_link_if.cs_n}, 16'h0001);
      $display("test wake done");
   endtask

   task automatic t_frames();
      run_frame(1'b0, 12'hA5C);
      pop_check(12'hA5C);
      run_frame(1'b1, 12'hFFF);
      pop_check(12'hFFF);
      $display("test frames done");
   endtask

   task automatic t_fifo();
      for (int i = 0; i < sar_pkg::FIFO_DEPTH; i++) run_frame(i[0], 12'(i * 273 + 15));
      req_valid = 1'b1;
      repeat (200) tick();
      check({14'h0000, req_ready, i_sar_link_if.cs_n}, 16'h0001);
      req_valid = 1'b0;
      for (int i = 0; i < sar_pkg::FIFO_DEPTH; i++) pop_check(12'(i * 273 + 15));
      tick();
      check({15'h0000, res_valid}, 16'h0000);
      $display("test fifo done");
   endtask

   task automatic t_abort();
      logic [15:0] bits;
      logic [15:0] bits3;
      bits = 16'h0000;
      bits3 = 16'h0000;
      code2 = 12'hFB6;
      i_sar_link_if_b.cs_n = 1'b0;
      i_sar_link_if_c.cs_n = 1'b0;
      #15;
      check({15'h0000, i_sar_link_if_b.serial_result_oe}, 16'h0001);
      check({14'h0000, active2, i_sar_link_if_c.serial_result_oe}, 16'h0003);
      for (int i = 1; i <= 12; i++) begin
         i_sar_link_if_b.sclk = 1'b1;
         i_sar_link_if_c.sclk = 1'b1;
         bits = {bits[14:0], i_sar_link_if_b.line_level};
         bits3 = {bits3[14:0], i_sar_link_if_c.line_level};
         #15;
         if (i < 12) begin
            i_sar_link_if_b.sclk = 1'b0;
            i_sar_link_if_c.sclk = 1'b0;
            #15;
         end
         if (i == 9) check({15'h0000, busy2}, 16'h0001);
         if (i == 10) check({15'h0000, busy2}, 16'h0000);
         if (i == 11) check({15'h0000, busy3}, 16'h0001);
      end
      check(bits, 16'h02D8);
      check(bits3, 16'h03B6);
      check({4'h0, last2}, 16'h00B6);
      check({4'h0, last3}, 16'h03B6);
      i_sar_link_if_b.cs_n = 1'b1;
      i_sar_link_if_c.cs_n = 1'b1;
      #1;
      check({15'h0000, i_sar_link_if_b.serial_result_oe}, 16'h0000);
      check({13'h0000, active2, active3, i_sar_link_if_c.serial_result_oe}, 16'h0000);
      i_sar_link_if_b.sclk = 1'b0;
      i_sar_link_if_c.sclk = 1'b0;
      $display("test abort done");
   endtask

   task automatic t_reset();
      logic [3:0] st;
      start_req(1'b1, 12'h5A5);
      repeat (50) tick();
      rstn = 1'b0;
      #1;
      st = {i_sar_link_if.cs_n, i_sar_link_if.serial_result_oe, awake, res_valid};
      check({12'h000, st}, 16'h0008);
      repeat (3) tick();
      rstn = 1'b1;
      wake_wait();
      run_frame(1'b0, 12'h800);
      pop_check(12'h800);
      $display("test reset done");
   endtask

   task automatic summarize();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      wake_req = 1'b0;
      req_valid = 1'b0;
      long_frame = 1'b0;
      res_ready = 1'b0;
      analog_code = 12'h000;
      code2 = 12'h000;
      fail_count = 0;
      comparisons = 0;
      i_sar_link_if_b.sclk = 1'b0;
      i_sar_link_if_b.cs_n = 1'b1;
      i_sar_link_if_c.sclk = 1'b0;
      i_sar_link_if_c.cs_n = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_wake();
      t_frames();
      t_fifo();
      t_abort();
      t_reset();
      summarize();
   end
endmodule // sar_adc_serial_readout_tb

`default_nettype wire
